// File: rtl/wdt_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH

// register indices; byte address is four times the index
`define WDT_IDX_COUNT 8'hA4
`define WDT_IDX_STATUS 8'hA5
`define WDT_IDX_SERVICE 8'hA6
`define WDT_IDX_PERIOD_CONFIG 8'hA7

// period config fields
`define WDT_SEL_LSB 0
`define WDT_SEL_MSB 2
`define WDT_SEL_RESET 3'h0

// status fields
`define WDT_STAT_STATE_LSB 0
`define WDT_STAT_STATE_MSB 1
`define WDT_STAT_PIN_BIT 2

// timing: core clocks per machine cycle, shortest timeout exponent
`define WDT_MACHINE_CYCLE_CLKS 12
`define WDT_BASE_EXPONENT 14
`define WDT_SEL_STEPS 7

`endif

// File: rtl/wdt_pkg.sv
// types shared by the watchdog and its bench
package wdt_pkg;

    // classic wishbone request bundle
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [11:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_t;

    // classic wishbone answer bundle
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wb_rsp_t;

    // power state of the watchdog
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_POWER_DOWN = 2'b01,
        ST_WAKE_HOLD = 2'b10
    } wdt_state_t;

endpackage : wdt_pkg

// File: rtl/watchdog_timeout_powerdown.sv
// hardware watchdog with power-down and wake-up hold logic
`timescale 1ns/10ps
`include "wdt_regs.svh"

module watchdog_timeout_powerdown #(
    parameter int MACHINE_CYCLE_CLKS = `WDT_MACHINE_CYCLE_CLKS,
    parameter int BASE_EXPONENT = `WDT_BASE_EXPONENT
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // register bus
    input wire wdt_pkg::wb_req_t wb_req_in,
    output wdt_pkg::wb_rsp_t wb_rsp_out,
    // core power control
    input wire logic pd_enter_in,
    input wire logic ext_int_enable_in,
    // external interrupt pin, active low
    input wire logic ext_int_n_in,
    // results to the core
    output logic wdt_reset_out,
    output logic osc_wake_out,
    output logic int_service_out
);
    import wdt_pkg::*;

    localparam int CNT_W = BASE_EXPONENT + `WDT_SEL_STEPS;
    localparam int PRE_W = $clog2(MACHINE_CYCLE_CLKS + 1);
    localparam logic [PRE_W-1:0] PRE_LAST =
        PRE_W'(MACHINE_CYCLE_CLKS - 1);

    // refuse settings the counter cannot serve
    generate
        if (MACHINE_CYCLE_CLKS < 1 || BASE_EXPONENT < 1 ||
            CNT_W > 31) begin : g_bad_param
            $error("watchdog parameters out of range");
        end
    endgenerate

    // timeout limit for a select code, in machine cycles
    function automatic logic [CNT_W-1:0] timeout_limit(
        input logic [2:0] sel
    );
        logic [CNT_W:0] one_hot;
        one_hot = '0;
        one_hot[BASE_EXPONENT + int'(sel)] = 1'b1;
        timeout_limit = CNT_W'(one_hot - 1'b1);
    endfunction : timeout_limit

    // word index from the byte address
    function automatic logic [9:0] word_index(input logic [11:0] adr);
        word_index = adr[11:2];
    endfunction : word_index

    // registers and state
    wdt_state_t state;
    wdt_state_t next_state;
    logic [2:0] timeout_select;
    logic [CNT_W-1:0] watchdog_counter;
    logic [PRE_W-1:0] prescale;
    logic pin_meta;
    logic pin_sync;
    logic pin_prev;
    logic ack;
    logic [31:0] rd_data;

    // bus decode
    logic req;
    logic wr_req;
    logic [9:0] idx;
    logic hit_period;
    logic hit_service;
    logic hit_status;
    logic hit_count;
    logic service;
    logic mc_tick;
    logic running;
    logic expire;

    assign req = wb_req_in.cyc & wb_req_in.stb & ~ack;
    assign wr_req = req & wb_req_in.we;
    assign idx = word_index(wb_req_in.adr);
    assign hit_period = (idx == 10'(`WDT_IDX_PERIOD_CONFIG));
    assign hit_service = (idx == 10'(`WDT_IDX_SERVICE));
    assign hit_status = (idx == 10'(`WDT_IDX_STATUS));
    assign hit_count = (idx == 10'(`WDT_IDX_COUNT));

    // a write to the service register with byte lane 0 selected restarts the count
    assign service = wr_req & hit_service & wb_req_in.sel[0];

    // pin synchroniser; only the second stage is looked at
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            pin_meta <= 1'b1;
            pin_sync <= 1'b1;
        end else begin
            pin_meta <= ext_int_n_in;
            pin_sync <= pin_meta;
        end
    end

    // previous pin level, for the rising edge after wake
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            pin_prev <= 1'b1;
        end else begin
            pin_prev <= pin_sync;
        end
    end

    // power state machine
    always_comb begin
        next_state = state;
        case (state)
            ST_RUN: begin
                // idle is not a state here: counting goes on
                if (pd_enter_in) begin
                    next_state = ST_POWER_DOWN;
                end
            end
            ST_POWER_DOWN: begin
                // level wake, only while the interrupt is enabled during power-down
                if (ext_int_enable_in && !pin_sync) begin
                    next_state = ST_WAKE_HOLD;
                end
            end
            ST_WAKE_HOLD: begin
                // low phase lets the oscillator settle
                if (pin_sync) begin
                    next_state = ST_RUN;
                end
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
    end

    // state register; a watchdog expiry behaves as a device reset
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            state <= ST_RUN;
        end else if (expire) begin
            state <= ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // counting only while running, never in power-down or wake hold
    assign running = (state == ST_RUN);

    // machine cycle prescaler
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            prescale <= '0;
        end else if (!running || service) begin
            prescale <= '0;
        end else if (prescale == PRE_LAST) begin
            prescale <= '0;
        end else begin
            prescale <= prescale + 1'b1;
        end
    end

    assign mc_tick = running && !service && (prescale == PRE_LAST);

    // expiry when the next machine cycle would reach the limit
    assign expire = mc_tick &&
        (watchdog_counter == timeout_limit(timeout_select) - 1'b1);

    // watchdog counter; service wins over a tick in the same cycle
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            watchdog_counter <= '0;
        end else if (service || expire) begin
            watchdog_counter <= '0;
        end else if (mc_tick) begin
            watchdog_counter <= watchdog_counter + 1'b1;
        end
    end

    // period config; expiry returns it to the reset select
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            timeout_select <= `WDT_SEL_RESET;
        end else if (expire) begin
            timeout_select <= `WDT_SEL_RESET;
        end else if (wr_req && hit_period && wb_req_in.sel[0]) begin
            timeout_select <=
                wb_req_in.dat[`WDT_SEL_MSB:`WDT_SEL_LSB];
        end
    end

    // device reset request, one clock per expiry
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            wdt_reset_out <= 1'b0;
        end else begin
            wdt_reset_out <= expire;
        end
    end

    // oscillator restart request while holding after a wake
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            osc_wake_out <= 1'b0;
        end else begin
            osc_wake_out <= (next_state == ST_WAKE_HOLD) && !expire;
        end
    end

    // hand the wake interrupt to the core on the pin's return high
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            int_service_out <= 1'b0;
        end else begin
            int_service_out <= (state == ST_WAKE_HOLD) &&
                pin_sync && !pin_prev;
        end
    end

    // bus ack: one cycle after the request, dropped the next cycle
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            ack <= 1'b0;
        end else begin
            ack <= req;
        end
    end

    // read data captured with the ack; unmapped reads give zero
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            rd_data <= 32'h0000_0000;
        end else if (req && !wb_req_in.we) begin
            rd_data <= 32'h0000_0000;
            if (hit_period) begin
                rd_data[`WDT_SEL_MSB:`WDT_SEL_LSB] <= timeout_select;
            end else if (hit_status) begin
                rd_data[`WDT_STAT_STATE_MSB:`WDT_STAT_STATE_LSB] <= state;
                rd_data[`WDT_STAT_PIN_BIT] <= pin_sync;
            end else if (hit_count) begin
                rd_data[CNT_W-1:0] <= watchdog_counter;
            end
        end
    end

    assign wb_rsp_out.ack = ack;
    assign wb_rsp_out.dat = rd_data;

endmodule : watchdog_timeout_powerdown

// File: verification/wdt_chk.sv
// concurrent checks on the watchdog ports
`timescale 1ns/10ps
module wdt_chk #(
    parameter int MACHINE_CYCLE_CLKS = 12,
    parameter int BASE_EXPONENT = 14
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // bus and core side
    input wire wdt_pkg::wb_req_t wb_req_in,
    input wire wdt_pkg::wb_rsp_t wb_rsp_out,
    input wire logic pd_enter_in,
    input wire logic ext_int_enable_in,
    input wire logic ext_int_n_in,
    // results
    input wire logic wdt_reset_out,
    input wire logic osc_wake_out,
    input wire logic int_service_out
);
    import wdt_pkg::*;
    logic [31:0] cnt;
    logic [2:0] sel;
    logic clean;
    logic in_pd;
    logic wr_take;
    int unsigned lim;
    // the block takes a write at the edge that sees it before its ack
    assign wr_take = wb_req_in.cyc && wb_req_in.stb && !wb_rsp_out.ack &&
        wb_req_in.we && wb_req_in.sel[0];
    assign lim = ((1 << (BASE_EXPONENT + sel)) - 1) * MACHINE_CYCLE_CLKS;
    // clocks since service; stale after power-down or period change
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            cnt <= 32'h0000_0000;
            sel <= 3'h0;
            clean <= 1'b1;
        end else if (wdt_reset_out) begin
            // expiry cleared the count at the edge that raised this pulse
            cnt <= 32'h0000_0001;
            sel <= 3'h0;
            clean <= 1'b1;
        end else begin
            cnt <= cnt + 32'h0000_0001;
            if (pd_enter_in) clean <= 1'b0;
            if (wr_take && wb_req_in.adr == 12'h29c) begin
                sel <= wb_req_in.dat[2:0];
                clean <= 1'b0;
            end
            if (wr_take && wb_req_in.adr == 12'h298) begin
                cnt <= 32'h0000_0000;
                clean <= 1'b1;
            end
        end
    end
    // power-down span, ends at wake hold
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            in_pd <= 1'b0;
        end else if (osc_wake_out) begin
            in_pd <= 1'b0;
        end else if (pd_enter_in) begin
            in_pd <= 1'b1;
        end
    end
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);
    sequence s_req;
        wb_req_in.cyc && wb_req_in.stb && !wb_rsp_out.ack;
    endsequence
    sequence s_pin_low;
        (!ext_int_n_in) [*3] ##0 osc_wake_out;
    endsequence
    AST_ACK_NEXT: assert property (s_req |=> wb_rsp_out.ack)
        else $error("ack missing one cycle after request");
    AST_ACK_PULSE: assert property (wb_rsp_out.ack |=> !wb_rsp_out.ack)
        else $error("ack longer than one cycle");
    AST_PD_HALT: assert property ($past(in_pd) && in_pd |-> !wdt_reset_out)
        else $error("watchdog reset during power-down");
    AST_WAKE_NEEDS_EN: assert property ($rose(osc_wake_out) |->
        $past(ext_int_enable_in) && in_pd)
        else $error("wake without enabled interrupt");
    AST_WAKE_HOLD: assert property (s_pin_low |=> osc_wake_out)
        else $error("wake hold left while pin low");
    AST_WAKE_NO_RST: assert property (osc_wake_out |-> !wdt_reset_out)
        else $error("watchdog reset during wake hold");
    AST_SVC_AFTER_WAKE: assert property (int_service_out |->
        ($past(osc_wake_out) || $past(osc_wake_out, 2)) &&
        $past(ext_int_n_in))
        else $error("wake service without hold and high pin");
    AST_NO_EARLY: assert property (wdt_reset_out && clean |-> cnt >= lim)
        else $error("watchdog reset too early");
    AST_NOT_LATE: assert property (clean |-> cnt <= lim)
        else $error("watchdog reset too late");
endmodule : wdt_chk

bind watchdog_timeout_powerdown wdt_chk #(
    .MACHINE_CYCLE_CLKS(MACHINE_CYCLE_CLKS),
    .BASE_EXPONENT(BASE_EXPONENT)
) u_chk (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .wb_req_in(wb_req_in), .wb_rsp_out(wb_rsp_out),
    .pd_enter_in(pd_enter_in), .ext_int_enable_in(ext_int_enable_in),
    .ext_int_n_in(ext_int_n_in), .wdt_reset_out(wdt_reset_out),
    .osc_wake_out(osc_wake_out), .int_service_out(int_service_out)
);

// File: verification/watchdog_timeout_powerdown_tb.sv
// self-checking bench for the watchdog block
`timescale 1ns/10ps
module watchdog_timeout_powerdown_tb;
    import wdt_pkg::*;
    localparam int BASE = 6;
    logic clk = 1'b0;
    logic rst = 1'b1;
    wb_req_t req = '0;
    wb_rsp_t rsp;
    logic pd = 1'b0;
    logic int_en = 1'b0;
    logic pin_n = 1'b1;
    logic wdt_rst, osc_wake, int_svc;
    logic [31:0] exp_q[$];
    int err_count = 0;
    int n_checks = 0;
    int seed = 8;
    int n;
    watchdog_timeout_powerdown #(.MACHINE_CYCLE_CLKS(1),
        .BASE_EXPONENT(BASE)) dut (.sys_clk_in(clk), .reset_in(rst),
        .wb_req_in(req), .wb_rsp_out(rsp), .pd_enter_in(pd),
        .ext_int_enable_in(int_en), .ext_int_n_in(pin_n),
        .wdt_reset_out(wdt_rst), .osc_wake_out(osc_wake),
        .int_service_out(int_svc));
    // 50 ns period
    always #25 clk = ~clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one classic cycle; waits for ack with no assumed latency
    task automatic bus(input logic we, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b1, we, a, 4'hf, d};
        do @(posedge clk); while (rsp.ack !== 1'b1);
        req <= '0;
    endtask : bus
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0000_0000);
    endtask : rd
    // read data is compared against the oldest note
    always @(posedge clk) begin
        if (rsp.ack === 1'b1 && req.we === 1'b0) chk(rsp.dat, exp_q.pop_front());
    end
    task automatic enter_pd;
        @(posedge clk) pd <= 1'b1;
        @(posedge clk) pd <= 1'b0;
    endtask : enter_pd
    task automatic wait_for(ref logic s, input int lim);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (s !== 1'b1 && n < lim);
    endtask : wait_for
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results
    // hang guard, about three and a half times the expected run
    initial begin
        #3000000;
        err_count++;
        results();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(12'h29c, 32'h0000_0000);
        rd(12'h3fc, 32'h0000_0000);
        for (int s = 0; s < 8; s++) begin
            bus(1'b1, 12'h298, 32'h0000_0000);
            bus(1'b1, 12'h29c, ($random(seed) & 32'hffff_fff8) | s);
            rd(12'h29c, s);
        end
        $display("test select codes done");
        // normal running stands in for idle: the count never pauses
        for (int s = 0; s < 8; s++) begin
            bus(1'b1, 12'h29c, s);
            bus(1'b1, 12'h298, 32'h0000_0000);
            wait_for(wdt_rst, 9000);
            // pulse is seen one full period after the service ack edge
            chk(n, (1 << (BASE + s)) - 1);
        end
        $display("test timeouts done");
        // periodic service keeps a running count from ever expiring
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, 12'h298, 32'h0000_0000);
            wait_for(wdt_rst, 40);
            chk(n, 40);
        end
        $display("test idle service done");
        bus(1'b1, 12'h298, 32'h0000_0000);
        int_en <= 1'b1;
        enter_pd();
        repeat (200) @(posedge clk);
        rd(12'h294, 32'h0000_0005);
        // three ticks between the service and the entry edge, then frozen
        rd(12'h290, 32'h0000_0003);
        pin_n <= 1'b0;
        repeat (150) @(posedge clk);
        chk(osc_wake, 1'b1);
        rd(12'h294, 32'h0000_0002);
        rd(12'h290, 32'h0000_0003);
        pin_n <= 1'b1;
        wait_for(int_svc, 20);
        chk(int_svc, 1'b1);
        bus(1'b1, 12'h298, 32'h0000_0000);
        $display("test interrupt wake done");
        int_en <= 1'b0;
        enter_pd();
        pin_n <= 1'b0;
        repeat (50) @(posedge clk);
        chk(osc_wake, 1'b0);
        rd(12'h294, 32'h0000_0001);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        pin_n <= 1'b1;
        bus(1'b1, 12'h298, 32'h0000_0000);
        rd(12'h294, 32'h0000_0004);
        $display("test reset exit done");
        results();
    end
endmodule : watchdog_timeout_powerdown_tb
